// ==== core/sdio_top.sv ====
// Discrete input/output device logic of a servo amplifier
//
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/1ps

// Functional notes
// - Torque select on applies smallest of three limits
// - Clear rising edge zeroes error, drops remaining travel
// - Clear mode 1 clears while clear held
// - Clear works for point-table and indexer alike
// - Pins follow assignment; defaults brake, in-position, malfunction
// - Brake delay parameter holds base drive after servo-off drops brake interlock
// - Brake interlock off on servo-off or alarm
// - Malfunction off when base drive shut off
// - Malfunction on 2.5-3.5 s after power-on
// - In-position while error magnitude within range
// - In-position only in position control mode
// - Dynamic brake interlock off when brake needed
module sdio_top #(
    parameter int MS_CYCLES         = sdio_pkg::MS_CYCLES,
    parameter int MALF_DELAY_CYCLES = sdio_pkg::MALF_DELAY_CYCLES
) (
    input  wire logic        CLK_IN,
    input  wire logic        SRST_IN,
    // Discrete pins
    input  wire logic        TRQ_LIM_SEL_IN,
    input  wire logic        POS_CLR_IN,
    // Internal status from the servo core, same clock
    input  wire logic        SERVO_ON_IN,
    input  wire logic        ALARM_IN,
    input  wire logic        BASE_SHUTOFF_IN,
    input  wire logic        DYN_BRAKE_REQ_IN,
    input  wire logic [1:0]  CTRL_MODE_IN,
    input  wire logic        CMD_PULSE_IN,
    input  wire logic        CMD_DIR_IN,
    input  wire logic        FB_PULSE_IN,
    input  wire logic        FB_DIR_IN,
    // Register port
    input  wire logic [7:0]  ADDR_IN,
    input  wire logic [31:0] WR_DATA_IN,
    input  wire logic        WR_IN,
    input  wire logic        RD_IN,
    output logic [31:0]      RD_DATA_OUT,
    // Outputs
    output logic             OUT_PIN_A_OUT,
    output logic             OUT_PIN_B_OUT,
    output logic             OUT_PIN_C_OUT,
    output logic             BASE_EN_OUT,
    output logic             REMAIN_DISCARD_OUT,
    output logic [31:0]      POS_ERR_OUT,
    output logic [31:0]      ACTIVE_TLIM_OUT
);

    // ==================================================================
    // Input synchronisers
    logic [1:0] pins_sync;
    logic       internal_torque_limit_select;
    logic       position_error_clear;

    sdio_sync #(.W(2)) u_sync (
        .clk_in   (CLK_IN),
        .srst_in  (SRST_IN),
        .async_in ({TRQ_LIM_SEL_IN, POS_CLR_IN}),
        .sync_out (pins_sync)
    );

    assign internal_torque_limit_select = pins_sync[1];
    assign position_error_clear         = pins_sync[0];

    // ==================================================================
    // Registers
    logic        clear_mode_param_ff;
    logic [2:0]  out_pin_a_assign_ff;
    logic [2:0]  out_pin_b_assign_ff;
    logic [2:0]  out_pin_c_assign_ff;
    logic [15:0] in_position_range_param_ff;
    logic [15:0] brake_delay_param_ff;
    logic [15:0] fwd_torque_limit_param_ff;
    logic [15:0] rev_torque_limit_param_ff;
    logic [15:0] internal_torque_limit_param_ff;

    always_ff @(posedge CLK_IN)
    begin
        if (SRST_IN)
        begin
            clear_mode_param_ff            <= sdio_pkg::CLR_MODE_RST;
            out_pin_a_assign_ff            <= sdio_pkg::PIN_A_RST;
            out_pin_b_assign_ff            <= sdio_pkg::PIN_B_RST;
            out_pin_c_assign_ff            <= sdio_pkg::PIN_C_RST;
            in_position_range_param_ff     <= sdio_pkg::INPOS_RANGE_RST;
            brake_delay_param_ff           <= sdio_pkg::BRAKE_DELAY_RST;
            fwd_torque_limit_param_ff      <= sdio_pkg::TLIM_RST;
            rev_torque_limit_param_ff      <= sdio_pkg::TLIM_RST;
            internal_torque_limit_param_ff <= sdio_pkg::TLIM_RST;
        end
        else if (WR_IN)
        begin
            unique case (ADDR_IN)
                sdio_pkg::ADDR_CTRL:
                    clear_mode_param_ff <= WR_DATA_IN[sdio_pkg::CTRL_CLR_MODE_BIT];
                sdio_pkg::ADDR_PIN_ASSIGN:
                begin
                    out_pin_a_assign_ff <= WR_DATA_IN[sdio_pkg::PIN_A_LSB +: sdio_pkg::SEL_W];
                    out_pin_b_assign_ff <= WR_DATA_IN[sdio_pkg::PIN_B_LSB +: sdio_pkg::SEL_W];
                    out_pin_c_assign_ff <= WR_DATA_IN[sdio_pkg::PIN_C_LSB +: sdio_pkg::SEL_W];
                end
                sdio_pkg::ADDR_INPOS_RANGE: in_position_range_param_ff     <= WR_DATA_IN[15:0];
                sdio_pkg::ADDR_BRAKE_DELAY: brake_delay_param_ff           <= WR_DATA_IN[15:0];
                sdio_pkg::ADDR_FWD_TLIM:    fwd_torque_limit_param_ff      <= WR_DATA_IN[15:0];
                sdio_pkg::ADDR_REV_TLIM:    rev_torque_limit_param_ff      <= WR_DATA_IN[15:0];
                sdio_pkg::ADDR_INT_TLIM:    internal_torque_limit_param_ff <= WR_DATA_IN[15:0];
                // Writes to read-only or unmapped addresses are dropped
                default: ;
            endcase
        end
    end

    // ==================================================================
    // Torque limit selection
    logic [15:0] min_fr;
    logic [15:0] min3;

    assign min_fr = (fwd_torque_limit_param_ff < rev_torque_limit_param_ff) ?
                    fwd_torque_limit_param_ff : rev_torque_limit_param_ff;
    assign min3   = (internal_torque_limit_param_ff < min_fr) ? internal_torque_limit_param_ff : min_fr;

    sdio_pkg::sdio_tlim_t nxt_tlim;

    always_comb
    begin
        if (internal_torque_limit_select)
        begin
            nxt_tlim.fwd = min3;
            nxt_tlim.rev = min3;
        end
        else
        begin
            nxt_tlim.fwd = fwd_torque_limit_param_ff;
            nxt_tlim.rev = rev_torque_limit_param_ff;
        end
    end

    always_ff @(posedge CLK_IN)
    begin
        if (SRST_IN)
            ACTIVE_TLIM_OUT <= '0;
        else
            ACTIVE_TLIM_OUT <= nxt_tlim;
    end

    // ==================================================================
    // Position error counter and clear
    logic clr_prev_ff;
    logic clr_edge;
    logic clr_now;
    logic signed [31:0] nxt_pos_err;
    logic signed [31:0] pos_err_ff;

    assign clr_edge = position_error_clear & ~clr_prev_ff;
    // Method of positioning plays no part: clear acts alike for both
    assign clr_now  = clr_edge | (clear_mode_param_ff & position_error_clear);

    always_ff @(posedge CLK_IN)
    begin
        if (SRST_IN)
            clr_prev_ff <= 1'b0;
        else
            clr_prev_ff <= position_error_clear;
    end

    always_comb
    begin
        nxt_pos_err = pos_err_ff;
        if (CMD_PULSE_IN)
            nxt_pos_err = CMD_DIR_IN ? nxt_pos_err - 32'sd1 : nxt_pos_err + 32'sd1;
        if (FB_PULSE_IN)
            nxt_pos_err = FB_DIR_IN ? nxt_pos_err + 32'sd1 : nxt_pos_err - 32'sd1;
    end

    always_ff @(posedge CLK_IN)
    begin
        if (SRST_IN)
            pos_err_ff <= '0;
        else if (clr_now)
            pos_err_ff <= '0;
        else
            pos_err_ff <= nxt_pos_err;
    end

    always_ff @(posedge CLK_IN)
    begin
        if (SRST_IN)
        begin
            REMAIN_DISCARD_OUT <= 1'b0;
            POS_ERR_OUT        <= '0;
        end
        else
        begin
            REMAIN_DISCARD_OUT <= clr_now;
            POS_ERR_OUT        <= pos_err_ff;
        end
    end

    // ==================================================================
    // In-position
    logic [31:0] err_mag;
    logic        in_position;

    assign err_mag     = pos_err_ff[31] ? 32'(-pos_err_ff) : 32'(pos_err_ff);
    assign in_position = (CTRL_MODE_IN == sdio_pkg::MODE_POS) &&
                         (err_mag <= {16'h0000, in_position_range_param_ff});

    // ==================================================================
    // Millisecond tick and brake sequencing
    logic [31:0] ms_cnt_ff;
    logic        ms_tick;

    assign ms_tick = (ms_cnt_ff == 32'(MS_CYCLES - 1));

    always_ff @(posedge CLK_IN)
    begin
        if (SRST_IN || ms_tick)
            ms_cnt_ff <= '0;
        else
            ms_cnt_ff <= ms_cnt_ff + 32'h0000_0001;
    end

    sdio_pkg::sdio_brk_state_t brk_state_ff;
    logic [15:0]               brk_cnt_ff;
    logic                      brake_interlock;

    // Base drive is held for the brake delay after servo-off so the
    // brake engages before torque is removed; an alarm cuts it at once.
    always_ff @(posedge CLK_IN)
    begin
        if (SRST_IN)
        begin
            brk_state_ff <= sdio_pkg::BRK_OFF;
            brk_cnt_ff   <= '0;
        end
        else if (ALARM_IN)
            brk_state_ff <= sdio_pkg::BRK_OFF;
        else
        begin
            unique case (brk_state_ff)
                sdio_pkg::BRK_OFF:
                    if (SERVO_ON_IN)
                        brk_state_ff <= sdio_pkg::BRK_ON;
                sdio_pkg::BRK_ON:
                    if (!SERVO_ON_IN)
                    begin
                        brk_state_ff <= sdio_pkg::BRK_HOLD;
                        brk_cnt_ff   <= '0;
                    end
                sdio_pkg::BRK_HOLD:
                    if (SERVO_ON_IN)
                        brk_state_ff <= sdio_pkg::BRK_ON;
                    else if (brk_cnt_ff > brake_delay_param_ff)
                        brk_state_ff <= sdio_pkg::BRK_OFF;
                    else if (ms_tick)
                        brk_cnt_ff <= brk_cnt_ff + 16'h0001;
            endcase
        end
    end

    assign brake_interlock = (brk_state_ff == sdio_pkg::BRK_ON) && SERVO_ON_IN && !ALARM_IN;

    always_ff @(posedge CLK_IN)
    begin
        if (SRST_IN)
            BASE_EN_OUT <= 1'b0;
        else
            BASE_EN_OUT <= !ALARM_IN && !BASE_SHUTOFF_IN && (SERVO_ON_IN || brk_state_ff != sdio_pkg::BRK_OFF);
    end

    // ==================================================================
    // Malfunction with power-on delay
    logic [31:0] pwr_cnt_ff;
    logic        pwr_ready_ff;
    logic        malfunction_out;

    always_ff @(posedge CLK_IN)
    begin
        if (SRST_IN)
        begin
            pwr_cnt_ff   <= '0;
            pwr_ready_ff <= 1'b0;
        end
        else if (!pwr_ready_ff)
        begin
            if (pwr_cnt_ff == 32'(MALF_DELAY_CYCLES - 1))
                pwr_ready_ff <= 1'b1;
            else
                pwr_cnt_ff <= pwr_cnt_ff + 32'h0000_0001;
        end
    end

    assign malfunction_out = pwr_ready_ff && !ALARM_IN && !BASE_SHUTOFF_IN;

    // ==================================================================
    // Output pin assignment
    sdio_pkg::sdio_dev_t devs;

    assign devs.brake_interlock     = brake_interlock;
    assign devs.in_position         = in_position;
    assign devs.malfunction_out     = malfunction_out;
    assign devs.dyn_brake_interlock = !DYN_BRAKE_REQ_IN;

    // Dynamic brake interlock reaches a pin only once software selects it
    sdio_pin_mux u_pin_a (
        .clk_in  (CLK_IN),
        .srst_in (SRST_IN),
        .sel_in  (out_pin_a_assign_ff),
        .dev_in  (devs),
        .pin_out (OUT_PIN_A_OUT)
    );

    sdio_pin_mux u_pin_b (
        .clk_in  (CLK_IN),
        .srst_in (SRST_IN),
        .sel_in  (out_pin_b_assign_ff),
        .dev_in  (devs),
        .pin_out (OUT_PIN_B_OUT)
    );

    sdio_pin_mux u_pin_c (
        .clk_in  (CLK_IN),
        .srst_in (SRST_IN),
        .sel_in  (out_pin_c_assign_ff),
        .dev_in  (devs),
        .pin_out (OUT_PIN_C_OUT)
    );

    // ==================================================================
    // Register read
    always_ff @(posedge CLK_IN)
    begin
        if (SRST_IN)
            RD_DATA_OUT <= '0;
        else if (RD_IN)
        begin
            RD_DATA_OUT <= '0;
            unique case (ADDR_IN)
                sdio_pkg::ADDR_CTRL:
                    RD_DATA_OUT[sdio_pkg::CTRL_CLR_MODE_BIT] <= clear_mode_param_ff;
                sdio_pkg::ADDR_PIN_ASSIGN:
                begin
                    RD_DATA_OUT[sdio_pkg::PIN_A_LSB +: sdio_pkg::SEL_W] <= out_pin_a_assign_ff;
                    RD_DATA_OUT[sdio_pkg::PIN_B_LSB +: sdio_pkg::SEL_W] <= out_pin_b_assign_ff;
                    RD_DATA_OUT[sdio_pkg::PIN_C_LSB +: sdio_pkg::SEL_W] <= out_pin_c_assign_ff;
                end
                sdio_pkg::ADDR_INPOS_RANGE: RD_DATA_OUT[15:0] <= in_position_range_param_ff;
                sdio_pkg::ADDR_BRAKE_DELAY: RD_DATA_OUT[15:0] <= brake_delay_param_ff;
                sdio_pkg::ADDR_FWD_TLIM:    RD_DATA_OUT[15:0] <= fwd_torque_limit_param_ff;
                sdio_pkg::ADDR_REV_TLIM:    RD_DATA_OUT[15:0] <= rev_torque_limit_param_ff;
                sdio_pkg::ADDR_INT_TLIM:    RD_DATA_OUT[15:0] <= internal_torque_limit_param_ff;
                sdio_pkg::ADDR_STATUS:
                begin
                    RD_DATA_OUT[sdio_pkg::STAT_BRAKE_BIT]   <= brake_interlock;
                    RD_DATA_OUT[sdio_pkg::STAT_INPOS_BIT]   <= in_position;
                    RD_DATA_OUT[sdio_pkg::STAT_MALF_BIT]    <= malfunction_out;
                    RD_DATA_OUT[sdio_pkg::STAT_DYNBRK_BIT]  <= devs.dyn_brake_interlock;
                    RD_DATA_OUT[sdio_pkg::STAT_BASE_EN_BIT] <= BASE_EN_OUT;
                    RD_DATA_OUT[sdio_pkg::STAT_TLSEL_BIT]   <= internal_torque_limit_select;
                    RD_DATA_OUT[sdio_pkg::STAT_CLR_BIT]     <= position_error_clear;
                end
                sdio_pkg::ADDR_POS_ERR: RD_DATA_OUT <= pos_err_ff;
                default: ;
            endcase
        end
        else
            RD_DATA_OUT <= '0;
    end

endmodule : sdio_top

// ==== core/sdio_pkg.sv ====
// Shared constants and types for the servo discrete I/O device block
package sdio_pkg;

    // ==================================================================
    // Timing
    localparam int CLK_PERIOD_NS     = 50;
    localparam int MS_NS             = 1000000;
    localparam int MS_CYCLES         = MS_NS / CLK_PERIOD_NS;
    // Middle of the allowed power-on window keeps margin on both sides
    localparam int MALF_DELAY_MS     = 3000;
    localparam int MALF_DELAY_CYCLES = MALF_DELAY_MS * MS_CYCLES;
    localparam int CLR_MIN_MS        = 10;

    // ==================================================================
    // Register offsets (byte addresses)
    localparam logic [7:0] ADDR_CTRL        = 8'h00;
    localparam logic [7:0] ADDR_PIN_ASSIGN  = 8'h04;
    localparam logic [7:0] ADDR_INPOS_RANGE = 8'h08;
    localparam logic [7:0] ADDR_BRAKE_DELAY = 8'h0c;
    localparam logic [7:0] ADDR_FWD_TLIM    = 8'h10;
    localparam logic [7:0] ADDR_REV_TLIM    = 8'h14;
    localparam logic [7:0] ADDR_INT_TLIM    = 8'h18;
    localparam logic [7:0] ADDR_STATUS      = 8'h1c;
    localparam logic [7:0] ADDR_POS_ERR     = 8'h20;

    // ==================================================================
    // Field positions
    localparam int CTRL_CLR_MODE_BIT = 0;
    localparam int PIN_A_LSB         = 0;
    localparam int PIN_B_LSB         = 4;
    localparam int PIN_C_LSB         = 8;
    localparam int SEL_W             = 3;
    localparam int STAT_BRAKE_BIT    = 0;
    localparam int STAT_INPOS_BIT    = 1;
    localparam int STAT_MALF_BIT     = 2;
    localparam int STAT_DYNBRK_BIT   = 3;
    localparam int STAT_BASE_EN_BIT  = 4;
    localparam int STAT_TLSEL_BIT    = 5;
    localparam int STAT_CLR_BIT      = 6;

    // ==================================================================
    // Types
    typedef enum logic [2:0] {
        SEL_NONE   = 3'h0,
        SEL_BRAKE  = 3'h1,
        SEL_INPOS  = 3'h2,
        SEL_MALF   = 3'h3,
        SEL_DYNBRK = 3'h4
    } sdio_sel_t;

    typedef enum logic [1:0] {
        MODE_POS = 2'h0,
        MODE_VEL = 2'h1,
        MODE_TRQ = 2'h2
    } sdio_mode_t;

    typedef enum {
        BRK_OFF,
        BRK_ON,
        BRK_HOLD
    } sdio_brk_state_t;

    typedef struct packed {
        logic dyn_brake_interlock;
        logic malfunction_out;
        logic in_position;
        logic brake_interlock;
    } sdio_dev_t;

    typedef struct packed {
        logic [15:0] fwd;
        logic [15:0] rev;
    } sdio_tlim_t;

    // ==================================================================
    // Reset values
    localparam logic        CLR_MODE_RST    = 1'b0;
    localparam sdio_sel_t   PIN_A_RST       = SEL_BRAKE;
    localparam sdio_sel_t   PIN_B_RST       = SEL_INPOS;
    localparam sdio_sel_t   PIN_C_RST       = SEL_MALF;
    localparam logic [15:0] INPOS_RANGE_RST = 16'h0064;
    localparam logic [15:0] BRAKE_DELAY_RST = 16'h0000;
    localparam logic [15:0] TLIM_RST        = 16'h03e8;

endpackage : sdio_pkg

// ==== core/sdio_sync.sv ====
// Two-flop synchroniser for asynchronous discrete inputs
`timescale 1ns/1ps
module sdio_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_in,
    input  wire logic         srst_in,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] meta_ff;

    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            meta_ff  <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_ff  <= async_in;
            sync_out <= meta_ff;
        end
    end

endmodule : sdio_sync

// ==== core/sdio_pin_mux.sv ====
// Registered selector placing one output device onto one output pin
`timescale 1ns/1ps
module sdio_pin_mux (
    input  wire logic              clk_in,
    input  wire logic              srst_in,
    input  wire logic [2:0]        sel_in,
    input  wire sdio_pkg::sdio_dev_t dev_in,
    output logic                   pin_out
);

    always_ff @(posedge clk_in)
    begin
        if (srst_in)
            pin_out <= 1'b0;
        else
        begin
            unique case (sel_in)
                sdio_pkg::SEL_NONE:   pin_out <= 1'b0;
                sdio_pkg::SEL_BRAKE:  pin_out <= dev_in.brake_interlock;
                sdio_pkg::SEL_INPOS:  pin_out <= dev_in.in_position;
                sdio_pkg::SEL_MALF:   pin_out <= dev_in.malfunction_out;
                sdio_pkg::SEL_DYNBRK: pin_out <= dev_in.dyn_brake_interlock;
                // Codes 5..7 are illegal; the pin stays off
                default:              pin_out <= 1'b0;
            endcase
        end
    end

endmodule : sdio_pin_mux

// ==== sim/sdio_top_properties.sv ====
// Port-level assertions for the discrete I/O block
`timescale 1ns/1ps
module sdio_top_properties #(
    parameter int MALF_DELAY_CYCLES = 50
) (
    input wire logic        CLK_IN,
    input wire logic        SRST_IN,
    input wire logic        TRQ_LIM_SEL_IN,
    input wire logic        POS_CLR_IN,
    input wire logic        CMD_PULSE_IN,
    input wire logic        CMD_DIR_IN,
    input wire logic        FB_PULSE_IN,
    input wire logic        RD_IN,
    input wire logic [31:0] RD_DATA_OUT,
    input wire logic        OUT_PIN_C_OUT,
    input wire logic        REMAIN_DISCARD_OUT,
    input wire logic [31:0] POS_ERR_OUT,
    input wire logic [31:0] ACTIVE_TLIM_OUT
);
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (SRST_IN);
    // ==========
    // Cycles since reset release, saturating
    logic [31:0] up_cnt_ff;
    always_ff @(posedge CLK_IN)
    begin
        if (SRST_IN)
            up_cnt_ff <= 32'h0;
        else if (up_cnt_ff < 32'(MALF_DELAY_CYCLES))
            up_cnt_ff <= up_cnt_ff + 32'h1;
    end
    // ==========
    // Checks
    property p_rst_quiet;
        $fell(SRST_IN) |-> !OUT_PIN_C_OUT && RD_DATA_OUT == 32'h0 && ACTIVE_TLIM_OUT == 32'h0;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("outputs active after reset");
    property p_rd_idle;
        !RD_IN |=> RD_DATA_OUT == 32'h0;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
    property p_clr_edge;
        $rose(POS_CLR_IN) |-> ##[3:5] REMAIN_DISCARD_OUT;
    endproperty
    a_clr_edge: assert property (p_clr_edge) else $error("clear edge not acted on");
    property p_clr_zero;
        REMAIN_DISCARD_OUT |=> POS_ERR_OUT == 32'h0;
    endproperty
    a_clr_zero: assert property (p_clr_zero) else $error("error not zero on clear");
    property p_clr_cause;
        REMAIN_DISCARD_OUT |-> $past(POS_CLR_IN, 4) || $past(POS_CLR_IN, 3);
    endproperty
    a_clr_cause: assert property (p_clr_cause) else $error("discard without clear");
    // Six quiet cycles keep any clear out of the pipeline
    property p_err_count;
        (!POS_CLR_IN [*6]) ##0 (CMD_PULSE_IN && !CMD_DIR_IN && !FB_PULSE_IN)
            |-> ##2 POS_ERR_OUT == $past(POS_ERR_OUT) + 32'h1;
    endproperty
    a_err_count: assert property (p_err_count) else $error("command pulse not counted");
    property p_tlim_sel;
        TRQ_LIM_SEL_IN [*5] |-> ACTIVE_TLIM_OUT[31:16] == ACTIVE_TLIM_OUT[15:0];
    endproperty
    a_tlim_sel: assert property (p_tlim_sel) else $error("limits differ while selected");
    property p_malf_early;
        up_cnt_ff + 32'h2 < 32'(MALF_DELAY_CYCLES) |-> !OUT_PIN_C_OUT;
    endproperty
    a_malf_early: assert property (p_malf_early) else $error("malfunction on too early");
endmodule : sdio_top_properties

bind sdio_top sdio_top_properties #(.MALF_DELAY_CYCLES(MALF_DELAY_CYCLES)) u_props (
    .CLK_IN(CLK_IN), .SRST_IN(SRST_IN), .TRQ_LIM_SEL_IN(TRQ_LIM_SEL_IN), .POS_CLR_IN(POS_CLR_IN),
    .CMD_PULSE_IN(CMD_PULSE_IN), .CMD_DIR_IN(CMD_DIR_IN), .FB_PULSE_IN(FB_PULSE_IN), .RD_IN(RD_IN),
    .RD_DATA_OUT(RD_DATA_OUT), .OUT_PIN_C_OUT(OUT_PIN_C_OUT), .REMAIN_DISCARD_OUT(REMAIN_DISCARD_OUT),
    .POS_ERR_OUT(POS_ERR_OUT), .ACTIVE_TLIM_OUT(ACTIVE_TLIM_OUT));

// ==== sim/sdio_seq_model.sv ====
// Behavioural sequencer issuing clear commands on the discrete pin
`timescale 1ns/1ps
module sdio_seq_model #(
    parameter int MS_CYCLES = 10
) (
    input  wire logic clk_in,
    input  wire logic srst_in,
    input  wire logic clr_go_in,
    output logic      clr_pin_out,
    output logic      busy_out
);
    // Two spare cycles so pin skew never shortens the minimum hold
    localparam int HOLD_CYCLES = 10 * MS_CYCLES + 2;
    int hold_cnt_ff;
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
            hold_cnt_ff <= 0;
        else if (clr_go_in && hold_cnt_ff == 0)
            hold_cnt_ff <= HOLD_CYCLES;
        else if (hold_cnt_ff != 0)
            hold_cnt_ff <= hold_cnt_ff - 1;
    end
    assign clr_pin_out = hold_cnt_ff != 0;
    assign busy_out    = hold_cnt_ff != 0;
endmodule : sdio_seq_model

// ==== sim/sdio_top_tb_top.sv ====
// Self-checking bench for the discrete I/O block
`timescale 1ns/1ps
module sdio_top_tb_top;
    localparam int MSC = 10;
    localparam int MDC = 50;
    localparam int TLS = 0, SRV = 1, ALR = 2, SHT = 3, DYN = 4, CLG = 5; // Bits of ctl
    logic        clk, srst, cmd_p, cmd_d, fb_p, fb_d, wr, rd;
    logic        pin_a, pin_b, pin_c, base_en, discard, clr_pin, clr_busy;
    logic [1:0]  mode;
    logic [5:0]  ctl;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata, tlim, perr;
    int          fail_count = 0, comparisons = 0;
    logic [31:0] rst_tab [8] = '{32'h0, 32'h321, 32'h64, 32'h0, 32'h3e8, 32'h3e8, 32'h3e8, 32'h0};
    logic [31:0] tl_int [3]  = '{32'h100, 32'h100, 32'h250};
    logic [31:0] tl_exp [3]  = '{32'h0200_0300, 32'h0100_0100, 32'h0200_0200};
    logic [31:0] st_exp [4]  = '{32'h5, 32'h3, 32'hffff_fffd, 32'hffff_fffe};
    int          st_n [4]    = '{5, 2, 6, 1};
    logic [3:0]  st_fb = 4'b1010;
    logic [3:0]  st_dir = 4'b1100;
    logic [3:0]  st_ip = 4'b1110;

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    sdio_top #(.MS_CYCLES(MSC), .MALF_DELAY_CYCLES(MDC)) dut (
        .CLK_IN(clk), .SRST_IN(srst), .TRQ_LIM_SEL_IN(ctl[TLS]), .POS_CLR_IN(clr_pin), .SERVO_ON_IN(ctl[SRV]),
        .ALARM_IN(ctl[ALR]), .BASE_SHUTOFF_IN(ctl[SHT]), .DYN_BRAKE_REQ_IN(ctl[DYN]), .CTRL_MODE_IN(mode),
        .CMD_PULSE_IN(cmd_p), .CMD_DIR_IN(cmd_d), .FB_PULSE_IN(fb_p), .FB_DIR_IN(fb_d), .ADDR_IN(addr),
        .WR_DATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RD_DATA_OUT(rdata), .OUT_PIN_A_OUT(pin_a),
        .OUT_PIN_B_OUT(pin_b), .OUT_PIN_C_OUT(pin_c), .BASE_EN_OUT(base_en), .REMAIN_DISCARD_OUT(discard),
        .POS_ERR_OUT(perr), .ACTIVE_TLIM_OUT(tlim));

    sdio_seq_model #(.MS_CYCLES(MSC)) u_seq (
        .clk_in(clk), .srst_in(srst), .clr_go_in(ctl[CLG]), .clr_pin_out(clr_pin), .busy_out(clr_busy));

    // ==========
    // Tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : wr_reg

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        check(rdata, exp);
    endtask : rd_chk

    // A low cycle between pulses so each counts once
    task automatic pulse(input logic fb, input logic dir, input int n);
        repeat (n)
        begin
            @(posedge clk);
            cmd_p <= !fb;
            fb_p  <= fb;
            cmd_d <= dir;
            fb_d  <= dir;
            @(posedge clk);
            cmd_p <= 1'b0;
            fb_p  <= 1'b0;
        end
    endtask : pulse

    task automatic drive(input int b, input logic val, input int n);
        @(posedge clk);
        ctl[b] <= val;
        cyc(n);
    endtask : drive

    task automatic final_report;
        $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : final_report

    // ==========
    // Tests
    initial
    begin
        srst = 1'b1;
        {ctl, cmd_p, cmd_d, fb_p, fb_d, wr, rd, mode, addr, wdata} = '0;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        cyc(MDC + 6);
        check(32'(pin_c), 32'h1);
        for (int i = 0; i < 8; i++)
            rd_chk(i == 7 ? 8'h24 : 8'(4 * i), rst_tab[i]);
        $display("power-on and reset values done");
        wr_reg(8'h10, 32'h200);
        wr_reg(8'h14, 32'h300);
        for (int i = 0; i < 3; i++)
        begin
            wr_reg(8'h18, tl_int[i]);
            drive(TLS, i > 0, 6);
            check(tlim, tl_exp[i]);
        end
        $display("torque limit done");
        wr_reg(8'h08, 32'h3);
        for (int i = 0; i < 4; i++)
        begin
            pulse(st_fb[i], st_dir[i], st_n[i]);
            cyc(4);
            check(perr, st_exp[i]);
            check(32'(pin_b), 32'(st_ip[i]));
        end
        rd_chk(8'h20, 32'hffff_fffe);
        for (int m = 2; m >= 0; m--)
        begin
            @(posedge clk);
            mode <= 2'(m);
            cyc(4);
            check(32'(pin_b), 32'(m == 0));
        end
        $display("error counter done");
        for (int m = 0; m < 2; m++)
        begin
            wr_reg(8'h00, 32'(m));
            drive(CLG, 1'b1, 0);
            drive(CLG, 1'b0, 8);
            check(perr, 32'h0);
            pulse(1'b0, 1'b0, 2);
            cyc(3);
            check(perr, m ? 32'h0 : 32'h2);
            for (int k = 0; k < 200 && clr_busy; k++)
                cyc(1);
            check(32'(clr_busy), 32'h0);
        end
        $display("clear done");
        drive(DYN, 1'b1, 2);
        for (int c = 0; c < 8; c++)
        begin
            wr_reg(8'h04, 32'h111 * 32'(c));
            cyc(3);
            check(32'({pin_a, pin_b, pin_c}), (c == 2 || c == 3) ? 32'h7 : 32'h0);
        end
        wr_reg(8'h04, 32'h444);
        drive(DYN, 1'b0, 3);
        check(32'({pin_a, pin_b, pin_c}), 32'h7);
        wr_reg(8'h04, 32'h321);
        rd_chk(8'h1c, 32'h2e);
        $display("pin assignment done");
        wr_reg(8'h0c, 32'h3);
        drive(SRV, 1'b1, 4);
        check(32'({pin_a, base_en}), 32'h3);
        drive(SRV, 1'b0, 4);
        check(32'({pin_a, base_en}), 32'h1);
        cyc(16);
        check(32'(base_en), 32'h1);
        cyc(30);
        check(32'(base_en), 32'h0);
        drive(SRV, 1'b1, 6);
        drive(ALR, 1'b1, 4);
        check(32'({pin_a, pin_c}), 32'h0);
        drive(ALR, 1'b0, 1);
        drive(SHT, 1'b1, 4);
        check(32'(pin_c), 32'h0);
        drive(SHT, 1'b0, 4);
        check(32'(pin_c), 32'h1);
        $display("brake and malfunction done");
        final_report;
    end

    initial
    begin
        repeat (5000) @(posedge clk);
        fail_count++;
        final_report;
    end
endmodule : sdio_top_tb_top
